// >>> wdg_pkg.sv
// Package: register map, flag positions and timing for the host link watchdog
package wdg_pkg;
    // Register numbers of the device (16-bit Modbus holding registers)
    localparam logic [15:0] SYS_STATUS_REG = 16'h03E7;
    localparam logic [15:0] HOST_CMD_REG = 16'h07CF;
    // Flag positions
    localparam int WDG_ACTIVE_BIT = 0;
    localparam int WDG_DISABLE_BIT = 1;
    localparam int SW_RESET_BIT = 2;
    localparam int WDG_EXPIRED_BIT = 3;
    localparam int HOST_RTU_BIT = 4;
    // Timeout defaults in microseconds, converted at 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int FB_TIMEOUT_US = 100;
    localparam int SSIO_TIMEOUT_US = 200;
    localparam int FB_TIMEOUT_CYC = FB_TIMEOUT_US * CLK_MHZ;
    localparam int SSIO_TIMEOUT_CYC = SSIO_TIMEOUT_US * CLK_MHZ;
    localparam int CNT_W = 32;
    // Controller Wishbone register offsets (byte addresses)
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS = 4'hC;
    // Controller control bits
    localparam int CTL_ENABLE = 0;
    localparam int CTL_DISABLE = 1;
    localparam int CTL_RESET = 2;
    localparam int CTL_POLL = 3;
    localparam int CTL_AUTO = 4;
    // Interrupt events
    localparam int IRQ_EXPIRED = 0;
    localparam int IRQ_DONE = 1;
endpackage : wdg_pkg

// >>> wdg_link_if.sv
// Interface: register request link between host master and device
`timescale 1ns/100ps
`default_nettype none
interface wdg_link_if;
    logic req;         // One-cycle valid request pulse
    logic we;          // Write request
    logic [15:0] addr; // Register number
    logic [15:0] wdata;
    logic ack;         // One-cycle answer pulse
    logic [15:0] rdata;
    modport host (output req, we, addr, wdata, input ack, rdata);
    modport dev (input req, we, addr, wdata, output ack, rdata);
endinterface : wdg_link_if
`default_nettype wire

// >>> wdg_timer.sv
// Watchdog down-counter loaded from its timeout, one per supervised side
`timescale 1ns/100ps
`default_nettype none
module wdg_timer import wdg_pkg::*; #(
    parameter int W = CNT_W
) (
    input wire logic i_ref_clk,      // System clock
    input wire logic i_rst,          // Async reset
    input wire logic i_run,          // Supervision active
    input wire logic i_kick,         // Reload pulse
    input wire logic [W-1:0] i_load, // Timeout in cycles
    output logic o_expired           // Reached zero while running
);
    logic [W-1:0] cnt_q, cnt_d;

    // Load the timeout while stopped or on kick, else count down and hold at zero
    always_comb begin
        cnt_d = cnt_q;
        if (!i_run || i_kick) begin
            cnt_d = i_load;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_expired = i_run && !i_kick && (cnt_q == '0);
endmodule : wdg_timer
`default_nettype wire

// >>> wdg_device.sv
// Device end: watchdog supervision of host requests and safe state
// Operation
// - Watchdog only with Modbus RTU host mode
// - Active flag in command register enables
// - Disable flag in command register disables
// - System register shows watchdog active flag
// - Enable or disable accepted any time
// - Host sends valid request each interval
// - Each valid request restarts the interval
// - Expiry clears synchronous serial outputs
// - Expiry clears fieldbus process data
// - Requests still answered after expiry
// - Only reset leaves the expired state
// - Separate timeouts for fieldbus and serial
// - Host response faster than smaller timeout
`timescale 1ns/100ps
`default_nettype none
module wdg_device import wdg_pkg::*; #(
    parameter int FB_CYC = FB_TIMEOUT_CYC,    // Fieldbus timeout cycles
    parameter int SSIO_CYC = SSIO_TIMEOUT_CYC // Serial timeout cycles
) (
    input wire logic i_ref_clk,         // 250 MHz clock
    input wire logic i_rst,             // Hardware reset, async high
    wdg_link_if.dev link,               // Host register link
    input wire logic i_rtu_mode,        // Host port set as RTU slave
    input wire logic [15:0] i_ssio_out, // Serial output image
    input wire logic [15:0] i_fb_data,  // Fieldbus process data
    output logic [15:0] o_ssio_out,     // Serial outputs to pins
    output logic [15:0] o_fb_data,      // Fieldbus process data out
    output logic o_safe,                // Safe state active
    output logic o_wdg_active           // Watchdog enabled
);
    // ****************************************************
    // Watchdog control state
    // ****************************************************
    logic act_q, act_d, exp_q, exp_d, srst_q, srst_d;
    logic ack_q, ack_d;
    logic [15:0] rdata_q, rdata_d, ssio_q, ssio_d, fb_q, fb_d;
    logic fb_exp, ssio_exp, cmd_wr, valid;

    // Valid request: any request addressed to us in RTU mode
    assign valid = link.req && i_rtu_mode;
    assign cmd_wr = valid && link.we && (link.addr == HOST_CMD_REG);

    // Two independent timers
    wdg_timer u_fb_tmr (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_run(act_q && !exp_q),
        .i_kick(valid),
        .i_load(CNT_W'(FB_CYC)),
        .o_expired(fb_exp)
    );
    wdg_timer u_ssio_tmr (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_run(act_q && !exp_q),
        .i_kick(valid),
        .i_load(CNT_W'(SSIO_CYC)),
        .o_expired(ssio_exp)
    );

    // Command decode, expiry and answers
    always_comb begin
        act_d = act_q;
        exp_d = exp_q;
        srst_d = 1'b0;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        if (!i_rtu_mode) begin
            act_d = 1'b0;
        end
        if (cmd_wr) begin
            // Any time during runtime
            if (link.wdata[WDG_ACTIVE_BIT]) begin
                act_d = 1'b1;
            end
            if (link.wdata[WDG_DISABLE_BIT]) begin
                act_d = 1'b0;
            end
            if (link.wdata[SW_RESET_BIT]) begin
                srst_d = 1'b1;
            end
        end
        if (fb_exp || ssio_exp) begin
            exp_d = 1'b1; // Sticky until reset
        end
        if (srst_q) begin
            act_d = 1'b0;
            exp_d = 1'b0;
        end
        if (valid) begin
            ack_d = 1'b1; // Answer even when expired
            rdata_d = 16'h0000;
            if (link.addr == SYS_STATUS_REG) begin
                rdata_d[WDG_ACTIVE_BIT] = act_q;
                rdata_d[WDG_EXPIRED_BIT] = exp_q;
                rdata_d[HOST_RTU_BIT] = i_rtu_mode;
            end
        end
    end

    // Safe-state output gating, registered
    always_comb begin
        ssio_d = exp_d ? 16'h0000 : i_ssio_out;
        fb_d = exp_d ? 16'h0000 : i_fb_data;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            act_q <= 1'b0;
            exp_q <= 1'b0;
            srst_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= 16'h0000;
            ssio_q <= 16'h0000;
            fb_q <= 16'h0000;
        end else begin
            act_q <= act_d;
            exp_q <= exp_d;
            srst_q <= srst_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ssio_q <= ssio_d;
            fb_q <= fb_d;
        end
    end

    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign o_ssio_out = ssio_q;
    assign o_fb_data = fb_q;
    assign o_safe = exp_q;
    assign o_wdg_active = act_q;
endmodule : wdg_device
`default_nettype wire

// >>> wdg_host.sv
// Host end: Wishbone-controlled master that drives the watchdog link
`timescale 1ns/100ps
`default_nettype none
module wdg_host import wdg_pkg::*; #(
    parameter int POLL_CYC = FB_TIMEOUT_CYC / 4 // Keep-alive spacing
) (
    input wire logic i_ref_clk,        // 250 MHz clock
    input wire logic i_rst,            // Async reset
    input wire logic i_wb_cyc,         // Wishbone cycle
    input wire logic i_wb_stb,         // Wishbone strobe
    input wire logic i_wb_we,          // Wishbone write
    input wire logic [3:0] i_wb_adr,   // Byte address
    input wire logic [3:0] i_wb_sel,   // Byte lanes
    input wire logic [31:0] i_wb_dat,  // Write data
    output logic [31:0] o_wb_dat,      // Read data
    output logic o_wb_ack,             // Acknowledge
    output logic o_irq,                // Level interrupt
    wdg_link_if.host link              // Link to device
);
    typedef enum {ST_IDLE, ST_WAIT} hst_t;
    hst_t st_q, st_d;
    logic [15:0] stat_q, stat_d;
    logic [4:0] ctl_q, ctl_d;
    logic [1:0] ist_q, ist_d, imsk_q, imsk_d;
    logic [31:0] rd_q, rd_d, tmr_q, tmr_d;
    logic ack_q, ack_d, irq_q, irq_d, req_q, req_d, we_q, we_d;
    logic [15:0] adr_q, adr_d, wd_q, wd_d;
    logic wb_go, wr_lo;

    assign wb_go = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr_lo = wb_go && i_wb_we && i_wb_sel[0];

    // ****************************************************
    // Bus slave, link sequencer and interrupts
    // ****************************************************
    always_comb begin
        st_d = st_q;
        ctl_d = ctl_q;
        stat_d = stat_q;
        ist_d = ist_q;
        imsk_d = imsk_q;
        rd_d = rd_q;
        ack_d = wb_go; // One wait state answer
        req_d = 1'b0;
        we_d = we_q;
        adr_d = adr_q;
        wd_d = wd_q;
        tmr_d = (tmr_q == 32'h0) ? 32'h0 : tmr_q - 32'h1;
        if (wb_go && !i_wb_we) begin
            case (i_wb_adr)
                CTRL_OFS: rd_d = {27'h0, ctl_q};
                STAT_OFS: rd_d = {16'h0, stat_q};
                IRQ_STAT_OFS: rd_d = {30'h0, ist_q};
                IRQ_MASK_OFS: rd_d = {30'h0, imsk_q};
                default: rd_d = 32'h0;
            endcase
        end
        if (wr_lo && i_wb_adr == CTRL_OFS) begin
            ctl_d = i_wb_dat[4:0];
        end
        if (wr_lo && i_wb_adr == IRQ_MASK_OFS) begin
            imsk_d = i_wb_dat[1:0];
        end
        if (wr_lo && i_wb_adr == IRQ_STAT_OFS) begin
            ist_d = ist_q & ~i_wb_dat[1:0];
        end
        case (st_q)
            ST_IDLE: begin
                if (ctl_q[CTL_ENABLE] || ctl_q[CTL_DISABLE]
                        || ctl_q[CTL_RESET]) begin
                    req_d = 1'b1;
                    we_d = 1'b1;
                    adr_d = HOST_CMD_REG;
                    wd_d = 16'h0000;
                    wd_d[WDG_ACTIVE_BIT] = ctl_q[CTL_ENABLE];
                    wd_d[WDG_DISABLE_BIT] = ctl_q[CTL_DISABLE];
                    wd_d[SW_RESET_BIT] = ctl_q[CTL_RESET];
                    ctl_d[2:0] = 3'h0;
                    st_d = ST_WAIT;
                end else if (ctl_q[CTL_POLL]
                        || (ctl_q[CTL_AUTO] && tmr_q == 32'h0)) begin
                    // Periodic read keeps the timer alive
                    req_d = 1'b1;
                    we_d = 1'b0;
                    adr_d = SYS_STATUS_REG;
                    ctl_d[CTL_POLL] = 1'b0;
                    tmr_d = 32'(POLL_CYC);
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (link.ack) begin
                    if (!we_q) begin
                        stat_d = link.rdata;
                        if (link.rdata[WDG_EXPIRED_BIT]) begin
                            ist_d[IRQ_EXPIRED] = 1'b1;
                        end
                    end
                    ist_d[IRQ_DONE] = 1'b1; // Set wins over clear
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        irq_d = |(ist_d & imsk_d);
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ST_IDLE;
            ctl_q <= 5'h00;
            stat_q <= 16'h0000;
            ist_q <= 2'h0;
            imsk_q <= 2'h0;
            rd_q <= 32'h0;
            tmr_q <= 32'h0;
            ack_q <= 1'b0;
            irq_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            adr_q <= 16'h0000;
            wd_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            ctl_q <= ctl_d;
            stat_q <= stat_d;
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            rd_q <= rd_d;
            tmr_q <= tmr_d;
            ack_q <= ack_d;
            irq_q <= irq_d;
            req_q <= req_d;
            we_q <= we_d;
            adr_q <= adr_d;
            wd_q <= wd_d;
        end
    end

    assign o_wb_dat = rd_q;
    assign o_wb_ack = ack_q;
    assign o_irq = irq_q;
    assign link.req = req_q;
    assign link.we = we_q;
    assign link.addr = adr_q;
    assign link.wdata = wd_q;
endmodule : wdg_host
`default_nettype wire

// >>> wdg_link_props.sv
// Checker: link handshake and safe-state assertions of the watchdog pair
`timescale 1ns/100ps
`default_nettype none
module wdg_link_props import wdg_pkg::*; #(
    parameter int FB_CYC = 50 // Smaller timeout in cycles
) (
    input wire logic i_ref_clk,         // Clock
    input wire logic i_rst,             // Async reset
    input wire logic i_rtu_mode,        // Host port mode
    input wire logic req,               // Link request
    input wire logic we,                // Link write
    input wire logic [15:0] addr,       // Register number
    input wire logic [15:0] wdata,      // Write data
    input wire logic ack,               // Link answer
    input wire logic [15:0] rdata,      // Read data
    input wire logic [15:0] o_ssio_out, // Serial outputs
    input wire logic [15:0] o_fb_data,  // Fieldbus data
    input wire logic o_safe,            // Safe state
    input wire logic o_wdg_active       // Watchdog enabled
);
    logic cmd_wr;
    logic soft_rst;
    logic [31:0] idle_q;
    logic [31:0] idle_d;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ************************************************************
    // Helper logic and assertions
    // ************************************************************
    assign cmd_wr = req && we && addr == HOST_CMD_REG && i_rtu_mode;
    assign soft_rst = cmd_wr && wdata[SW_RESET_BIT];
    // Cycles since last taken request; saturates so it never wraps
    always_comb begin
        idle_d = idle_q;
        if (req && i_rtu_mode) begin
            idle_d = '0;
        end else if (idle_q != 32'hFFFF) begin
            idle_d = idle_q + 32'h1;
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            idle_q <= '0;
        end else begin
            idle_q <= idle_d;
        end
    end
    ack_follows_req_a: assert property (req && i_rtu_mode |=> ack)
        else $error("link request not answered");
    no_ack_off_a: assert property (req && !i_rtu_mode |=> !ack)
        else $error("request answered outside RTU mode");
    enable_cmd_a: assert property (cmd_wr && wdata[0] && !wdata[1]
        && !wdata[2] |-> ##[1:3] o_wdg_active) else $error("enable lost");
    disable_cmd_a: assert property (cmd_wr && wdata[WDG_DISABLE_BIT]
        |-> ##[1:3] !o_wdg_active) else $error("disable lost");
    status_read_a: assert property (ack && $past(req && !we
        && addr == SYS_STATUS_REG) |-> rdata[WDG_ACTIVE_BIT] == o_wdg_active
        && rdata[HOST_RTU_BIT]) else $error("status word wrong");
    safe_zero_a: assert property (o_safe [*2] |-> o_ssio_out == '0
        && o_fb_data == '0) else $error("outputs not cleared");
    safe_sticky_a: assert property ($fell(o_safe) |-> $past(soft_rst, 2)
        || $past(soft_rst, 3)) else $error("safe left without reset");
    idle_quiet_a: assert property (!o_wdg_active && !o_safe |=> !o_safe)
        else $error("expiry while disabled");
    expiry_time_a: assert property ($rose(o_safe) |-> idle_q >= FB_CYC - 2
        && idle_q <= FB_CYC + 3) else $error("expiry at wrong time");
    expiry_due_a: assert property (o_wdg_active && idle_q == FB_CYC + 4
        |-> o_safe) else $error("expiry missed");
endmodule : wdg_link_props
`default_nettype wire

// >>> host_link_watchdog_tb.sv
// Testbench: host and device ends of the watchdog joined by their link
`timescale 1ns/100ps
`default_nettype none
module host_link_watchdog_tb import wdg_pkg::*;;
    logic clk, rst, cyc, stb, wb_we, ack, irq, rtu, safe, active;
    logic [3:0] adr;
    logic [31:0] dat_w, dat_r;
    logic [15:0] ssio_in, fb_in, ssio_out, fb_out;
    int errors = 0;
    int tests_run = 0;
    wdg_link_if link ();
    wdg_host #(.POLL_CYC(10)) wdg_host_inst (.i_ref_clk(clk), .i_rst(rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(wb_we), .i_wb_adr(adr),
        .i_wb_sel(4'hF), .i_wb_dat(dat_w), .o_wb_dat(dat_r), .o_wb_ack(ack),
        .o_irq(irq), .link(link.host));
    wdg_device #(.FB_CYC(50), .SSIO_CYC(80)) wdg_device_inst (.i_ref_clk(clk),
        .i_rst(rst), .link(link.dev), .i_rtu_mode(rtu), .i_ssio_out(ssio_in),
        .i_fb_data(fb_in), .o_ssio_out(ssio_out), .o_fb_data(fb_out),
        .o_safe(safe), .o_wdg_active(active));
    wdg_link_props #(.FB_CYC(50)) wdg_link_props_inst (.i_ref_clk(clk),
        .i_rst(rst), .i_rtu_mode(rtu), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata), .o_ssio_out(ssio_out), .o_fb_data(fb_out),
        .o_safe(safe), .o_wdg_active(active));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    // One classic cycle; read data compared at the ack edge
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        wb_we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (!w) check(dat_r, exp);
        if (n >= 50) errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
    endtask : wb
    // Bounded wait for safe and active flags, then compare both
    task automatic expect_st(input logic s, input logic a);
        for (int k = 0; k < 300; k++) begin
            @(posedge clk);
            #1;
            if (safe === s && active === a) break;
        end
        check({safe, active}, {s, a});
    endtask : expect_st
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    // ************************************************************
    // Clock, watchdog and main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run is under a thousand cycles; this span of 25000 cycles means a hang
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
    initial begin
        {rst, rtu, cyc, stb, wb_we, adr, dat_w} = {2'b11, 39'h0};
        ssio_in = 16'hA5C3;
        fb_in = 16'h3C5A;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wb(0, IRQ_STAT_OFS, 0, 0);
        wb(0, IRQ_MASK_OFS, 0, 0);
        wb(0, 4'h2, 0, 0);
        wb(1, IRQ_MASK_OFS, 32'h3, 0);
        wb(1, CTRL_OFS, 32'h1, 0);
        expect_st(0, 1);
        wb(1, CTRL_OFS, 32'h8, 0);
        idle(10);
        wb(0, STAT_OFS, 0, 32'h11);
        wb(1, CTRL_OFS, 32'h10, 0);
        idle(300);
        check(safe, 0);
        check({ssio_out, fb_out}, {ssio_in, fb_in});
        wb(1, CTRL_OFS, 0, 0);
        expect_st(1, 1);
        idle(2);
        check({ssio_out, fb_out}, 0);
        // Link transfers so far raised only the done event
        check(irq, 1);
        wb(1, IRQ_MASK_OFS, 32'h1, 0);
        check(irq, 0);
        wb(1, IRQ_STAT_OFS, 32'h3, 0);
        wb(0, IRQ_STAT_OFS, 0, 32'h0);
        wb(1, CTRL_OFS, 32'h8, 0);
        idle(10);
        wb(0, STAT_OFS, 0, 32'h19);
        check(irq, 1);
        wb(0, IRQ_STAT_OFS, 0, 32'h3);
        wb(1, CTRL_OFS, 32'h1, 0);
        idle(20);
        check(safe, 1);
        wb(1, CTRL_OFS, 32'h4, 0);
        expect_st(0, 0);
        idle(2);
        check({ssio_out, fb_out}, {ssio_in, fb_in});
        wb(1, CTRL_OFS, 32'h1, 0);
        expect_st(0, 1);
        wb(1, CTRL_OFS, 32'h2, 0);
        expect_st(0, 0);
        idle(200);
        check(safe, 0);
        wb(1, CTRL_OFS, 32'h3, 0);
        idle(20);
        check(active, 0);
        wb(1, CTRL_OFS, 32'h1, 0);
        expect_st(1, 1);
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        expect_st(0, 0);
        wb(1, CTRL_OFS, 32'h1, 0);
        expect_st(0, 1);
        rtu <= 1'b0;
        expect_st(0, 0);
        end_of_test();
    end
endmodule : host_link_watchdog_tb
`default_nettype wire
